// file: hdl/smt_pkg.sv
/*
 * Package for the SPI master transfer control block: widths, mode
 * codes, clock source codes and a control carrier struct.
 * Assumes a single mclk domain; no register bus.
 */
package smt_pkg;
  // -----------------------------------------------------------------
  // Widths and depths
  // -----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int BAUD_W = 8;
  localparam int FIFO_DEPTH = 2;
  localparam int FIFO_AW = 1;
  localparam int SRC_N = 8;
  localparam int SRC_W = 3;
  // Bit index of the msb within a word
  localparam logic [2:0] MSB_IDX = 3'h7;
  localparam logic [3:0] BITS_PER_WORD = 4'h8;

  // -----------------------------------------------------------------
  // Clock source codes
  // -----------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_SYS_OSC = 3'h0;
  localparam logic [SRC_W-1:0] SRC_HF_OSC = 3'h1;
  localparam logic [SRC_W-1:0] SRC_REF_CLK = 3'h2;
  localparam logic [SRC_W-1:0] SRC_TMR_OVF = 3'h3;
  localparam logic [SRC_W-1:0] SRC_TMR_PS_A = 3'h4;
  localparam logic [SRC_W-1:0] SRC_TMR_PS_B = 3'h5;
  localparam logic [SRC_W-1:0] SRC_TMR_PS_C = 3'h6;
  localparam logic [SRC_W-1:0] SRC_TMR_MATCH = 3'h7;

  // -----------------------------------------------------------------
  // Reset values and carriers
  // -----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 8'h00;

  typedef enum logic [1:0] {
    SMT_OFF, SMT_TX_ONLY, SMT_RX_ONLY, SMT_DUPLEX
  } smt_mode_e;

  typedef struct packed {
    logic tx_enable_ctl;
    logic rx_enable_ctl;
    logic counter_mode_ctl;
    logic sel_force_ctl;
    logic sel_polarity_ctl;
    logic sel_hw_ctl;
    logic clk_polarity_ctl;
    logic clk_phase_ctl;
    logic sample_point_ctl;
    logic fast_start_ctl;
    logic bit_order_ctl;
    logic master_en;
  } smt_ctl_s;
endpackage

// file: hdl/smt_master.sv
/*
 * SPI master transfer control: tx-only, rx-only, duplex and off modes, a
 * transfer counter, two small FIFOs, slave-select, clock source and
 * baud division, phase/polarity/sample, and start-up delay.
 * Assumes software honours the shift-empty flag before mode changes
 * and that clock sources are pins sampled in mclk.
 */
`timescale 1ns/100ps
module smt_master #(
  parameter int DEPTH = smt_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Controls
  input wire smt_pkg::smt_ctl_s ctl,
  input wire logic [smt_pkg::SRC_W-1:0] clk_source_sel,
  input wire logic [smt_pkg::BAUD_W-1:0] baud_divisor,
  input wire logic [smt_pkg::SRC_N-1:0] clk_sources,
  // Transfer count port
  input wire logic [smt_pkg::CNT_W-1:0] xfer_count_wdata,
  input wire logic xfer_count_low_wr,
  output logic [smt_pkg::CNT_W-1:0] xfer_count,
  // Tx buffer port
  input wire logic [smt_pkg::DATA_W-1:0] tx_buffer_port,
  input wire logic tx_valid,
  output logic tx_ready,
  // Rx buffer port
  output logic [smt_pkg::DATA_W-1:0] rx_buffer_port,
  output logic rx_valid,
  input wire logic rx_ready,
  // Status
  output logic shift_empty_flag,
  output logic count_zero_flag,
  input wire logic count_zero_clr,
  // SPI pins
  output logic sck_out,
  output logic sdo_out,
  input wire logic sdi_in,
  output logic sel_out,
  output logic sel_oe
);
  import smt_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers (three flops, accept when last two agree)
  // ---------------------------------------------------------------
  logic [SRC_N-1:0] src_s1_r, src_s2_r, src_s3_r, src_r;
  logic [2:0] sdi_sync_r;
  logic sdi_r;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      src_s1_r <= '0;
      src_s2_r <= '0;
      src_s3_r <= '0;
      src_r <= '0;
      sdi_sync_r <= '0;
      sdi_r <= 1'b0;
    end else begin
      src_s1_r <= clk_sources;
      src_s2_r <= src_s1_r;
      src_s3_r <= src_s2_r;
      src_r <= (src_s2_r & src_s3_r) | (src_r & (src_s2_r | src_s3_r));
      sdi_sync_r <= {sdi_sync_r[1:0], sdi_in};
      if (sdi_sync_r[1] == sdi_sync_r[2])
        sdi_r <= sdi_sync_r[2];
    end
  end

  // ---------------------------------------------------------------
  // Selected clock tick and baud divider
  // ---------------------------------------------------------------
  logic sel_clk_prev_r;
  logic src_tick;
  logic [BAUD_W-1:0] baud_cnt_r;
  logic half_tick;
  always_ff @(posedge mclk) begin
    if (!reset_n)
      sel_clk_prev_r <= 1'b0;
    else
      sel_clk_prev_r <= src_r[clk_source_sel];
  end
  assign src_tick = src_r[clk_source_sel] & ~sel_clk_prev_r;
  // Half an SCK period is divisor+1 source ticks
  assign half_tick = src_tick && (baud_cnt_r == baud_divisor);

  // ---------------------------------------------------------------
  // FIFOs
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] txq [DEPTH];
  logic [DATA_W-1:0] rxq [DEPTH];
  logic [FIFO_AW:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic tx_empty, rx_full, tx_push, tx_pop, rx_push;
  assign tx_empty = tx_wp_r == tx_rp_r;
  assign tx_ready = (tx_wp_r - tx_rp_r) != (FIFO_AW+1)'(DEPTH);
  assign tx_push = tx_valid && tx_ready;
  assign rx_full = (rx_wp_r - rx_rp_r) == (FIFO_AW+1)'(DEPTH);
  assign rx_valid = rx_wp_r != rx_rp_r;
  assign rx_buffer_port = rxq[rx_rp_r[FIFO_AW-1:0]];

  // ---------------------------------------------------------------
  // Mode decode and transfer gating
  // ---------------------------------------------------------------
  smt_mode_e mode;
  logic cnt_nz, go;
  always_comb begin
    unique case ({ctl.tx_enable_ctl, ctl.rx_enable_ctl})
      2'b10: mode = SMT_TX_ONLY;
      2'b01: mode = SMT_RX_ONLY;
      2'b11: mode = SMT_DUPLEX;
      2'b00: mode = SMT_OFF;
    endcase
  end
  assign cnt_nz = xfer_count != CNT_RESET;
  always_comb begin
    go = 1'b0;
    unique case (mode)
      // Mode 1 ignores count for tx-only and duplex; mode 0 and rx-only need written nonzero count
      SMT_TX_ONLY: go = !tx_empty &&
        (ctl.counter_mode_ctl || cnt_nz);
      SMT_RX_ONLY: go = !rx_full && cnt_nz;
      SMT_DUPLEX: go = !tx_empty && !rx_full &&
        (ctl.counter_mode_ctl || cnt_nz);
      SMT_OFF: go = 1'b0;
    endcase
    go = go && ctl.master_en;
  end

  // ---------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SYNC, ST_DELAY, ST_LEAD, ST_TRAIL, ST_TAIL
  } smt_state_e;
  smt_state_e state_r;
  logic [DATA_W-1:0] shreg_r, last_rx_r;
  logic [3:0] bit_cnt_r;
  logic sync_cnt_r, tail_cnt_r, sck_act_r, sdo_r, done;
  logic rx_bit_r, shift_in;
  logic [DATA_W-1:0] tx_word, shreg_nxt;
  // Rx-only resends the head or the last received word
  assign tx_word = tx_empty ? last_rx_r : txq[tx_rp_r[FIFO_AW-1:0]];
  // Trail sampling reads the pin at the shift edge; lead uses the held bit
  assign shift_in = ctl.sample_point_ctl ? sdi_r : rx_bit_r;
  // Stores take the shifted word so the last bit is not lost
  assign shreg_nxt = ctl.bit_order_ctl ? {shift_in, shreg_r[DATA_W-1:1]}
                                       : {shreg_r[DATA_W-2:0], shift_in};
  assign done = (state_r == ST_TRAIL) && half_tick &&
                (bit_cnt_r == BITS_PER_WORD);
  assign tx_pop = (state_r == ST_SYNC) && half_tick && sync_cnt_r &&
                  (mode != SMT_RX_ONLY) && !tx_empty;
  assign rx_push = done && mode != SMT_TX_ONLY && !rx_full;
  assign shift_empty_flag = state_r == ST_IDLE;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      sync_cnt_r <= 1'b0;
      tail_cnt_r <= 1'b0;
      sck_act_r <= 1'b0;
      shreg_r <= '0;
      baud_cnt_r <= BAUD_RESET;
    end else begin
      if (src_tick)
        baud_cnt_r <= half_tick ? BAUD_RESET : baud_cnt_r + 8'h01;
      unique case (state_r)
        ST_IDLE: if (go) begin
          state_r <= ST_SYNC;
          sync_cnt_r <= 1'b0;
        end
        // Two baud half-ticks (divisor+1 selected-clock ticks each) to align the trigger
        ST_SYNC: if (half_tick) begin
          sync_cnt_r <= 1'b1;
          if (sync_cnt_r) begin
            shreg_r <= tx_word;
            bit_cnt_r <= 4'h0;
            state_r <= ctl.fast_start_ctl ? ST_LEAD : ST_DELAY;
          end
        end
        ST_DELAY: if (half_tick) state_r <= ST_LEAD;
        ST_LEAD: if (half_tick) begin
          sck_act_r <= 1'b1;
          state_r <= ST_TRAIL;
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        ST_TRAIL: if (half_tick) begin
          sck_act_r <= 1'b0;
          shreg_r <= shreg_nxt;
          if (bit_cnt_r != BITS_PER_WORD)
            state_r <= ST_LEAD;
          else begin
            state_r <= ST_TAIL;
            tail_cnt_r <= 1'b0;
          end
        end
        // Gap after a word; longer for phase/sample 0/1
        ST_TAIL: if (half_tick) begin
          tail_cnt_r <= 1'b1;
          if (tail_cnt_r || !(!ctl.clk_phase_ctl && ctl.sample_point_ctl))
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Lead-edge sample held until the shift at the trail edge
  always_ff @(posedge mclk) begin
    if (!reset_n)
      rx_bit_r <= 1'b0;
    else if (half_tick && state_r == ST_LEAD)
      rx_bit_r <= sdi_r;
  end

  // SDO: phase set drives before first edge
  logic [DATA_W-1:0] out_word;
  assign out_word = (state_r == ST_SYNC) ? tx_word : shreg_r;
  always_ff @(posedge mclk) begin
    if (!reset_n)
      sdo_r <= 1'b0;
    else if (state_r == ST_IDLE)
      sdo_r <= 1'b0;
    else if (ctl.clk_phase_ctl || sck_act_r || state_r == ST_TRAIL)
      sdo_r <= ctl.bit_order_ctl ? out_word[0]
                                 : out_word[MSB_IDX];
  end
  assign sdo_out = sdo_r;

  always_ff @(posedge mclk) begin
    if (!reset_n)
      sck_out <= 1'b0;
    else
      sck_out <= sck_act_r ^ ctl.clk_polarity_ctl;
  end

  // ---------------------------------------------------------------
  // FIFO pointers and storage
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      last_rx_r <= '0;
    end else begin
      if (tx_push) begin
        txq[tx_wp_r[FIFO_AW-1:0]] <= tx_buffer_port;
        tx_wp_r <= tx_wp_r + 1'b1;
      end
      if (tx_pop) tx_rp_r <= tx_rp_r + 1'b1;
      if (done) last_rx_r <= shreg_nxt;
      if (rx_push) begin
        rxq[rx_wp_r[FIFO_AW-1:0]] <= shreg_nxt;
        rx_wp_r <= rx_wp_r + 1'b1;
      end
      if (rx_valid && rx_ready) rx_rp_r <= rx_rp_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Transfer counter and zero flag
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n)
      xfer_count <= CNT_RESET;
    else if (xfer_count_low_wr)
      xfer_count <= xfer_count_wdata;
    else if (done)
      xfer_count <= xfer_count - CNT_ONE;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n)
      count_zero_flag <= 1'b0;
    else if (done && xfer_count == CNT_ONE)
      count_zero_flag <= 1'b1;
    else if (count_zero_clr)
      count_zero_flag <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Slave select
  // ---------------------------------------------------------------
  logic sel_act_r;
  always_ff @(posedge mclk) begin
    if (!reset_n)
      sel_act_r <= 1'b0;
    else if (xfer_count_low_wr)
      sel_act_r <= xfer_count_wdata != CNT_RESET;
    else if (!cnt_nz && state_r == ST_IDLE)
      sel_act_r <= 1'b0;
  end
  // Output only in master hardware mode; the pin is software's otherwise
  assign sel_oe = ctl.master_en && ctl.sel_hw_ctl;
  assign sel_out = sel_oe &&
    (ctl.sel_force_ctl || sel_act_r) ? !ctl.sel_polarity_ctl
                                     : ctl.sel_polarity_ctl;
endmodule

// file: sim/smt_master_asserts.sv
/* Port checker for smt_master, attached by bind.
   Assumes one mclk domain and select active level set by polarity. */
`timescale 1ns/100ps
module smt_master_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Watched ports
  input wire smt_pkg::smt_ctl_s ctl,
  input wire logic xfer_count_low_wr,
  input wire logic [smt_pkg::CNT_W-1:0] xfer_count,
  input wire logic rx_valid,
  input wire logic shift_empty_flag,
  input wire logic count_zero_flag,
  input wire logic sck_out,
  input wire logic sel_out,
  input wire logic sel_oe
);
  import smt_pkg::*;
  logic tx_only;
  logic rx_only;
  logic idle2;
  assign tx_only = ctl.tx_enable_ctl && !ctl.rx_enable_ctl;
  assign rx_only = ctl.rx_enable_ctl && !ctl.tx_enable_ctl;
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Sync and delay keep sck still for a while after a start
  sequence s_go;
    $fell(shift_empty_flag);
  endsequence
  sequence s_quiet;
    $stable(sck_out)[*3];
  endsequence
  property p_sync;
    s_go |-> s_quiet;
  endproperty
  a_sync: assert property (p_sync)
    else $error("sck moved too soon after start");
  property p_sel_oe;
    !(ctl.master_en && ctl.sel_hw_ctl)
      |-> !sel_oe && sel_out == ctl.sel_polarity_ctl;
  endproperty
  a_sel_oe: assert property (p_sel_oe)
    else $error("select driven outside hardware mode");
  property p_sel_force;
    ctl.sel_force_ctl && sel_oe |-> sel_out == !ctl.sel_polarity_ctl;
  endproperty
  a_sel_force: assert property (p_sel_force)
    else $error("forced select not active");
  assign idle2 = shift_empty_flag && xfer_count == CNT_RESET;
  property p_sel_idle;
    idle2 && $past(idle2) && !ctl.sel_force_ctl
      |-> sel_out == ctl.sel_polarity_ctl;
  endproperty
  a_sel_idle: assert property (p_sel_idle)
    else $error("select active with zero count");
  property p_sck_idle;
    shift_empty_flag && $past(shift_empty_flag)
      |-> sck_out == ctl.clk_polarity_ctl;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("sck idle level wrong");
  property p_no_store;
    (tx_only || !ctl.rx_enable_ctl) && !rx_valid |=> !rx_valid;
  endproperty
  a_no_store: assert property (p_no_store)
    else $error("word stored without receive");
  property p_stop_zero;
    idle2 && !xfer_count_low_wr
      && (rx_only || tx_only && !ctl.counter_mode_ctl)
      |=> shift_empty_flag;
  endproperty
  a_stop_zero: assert property (p_stop_zero)
    else $error("transfer began at zero count");
  property p_czf;
    $rose(count_zero_flag) |-> xfer_count == CNT_RESET;
  endproperty
  a_czf: assert property (p_czf)
    else $error("zero flag set with nonzero count");
endmodule
bind smt_master smt_master_asserts u_smt_master_asserts (.mclk,
  .reset_n, .ctl, .xfer_count_low_wr, .xfer_count, .rx_valid,
  .shift_empty_flag, .count_zero_flag, .sck_out, .sel_out, .sel_oe);

// file: sim/smt_slave_model.sv
/* Behavioural SPI slave: shifts a fixed reply out, records sdo.
   Assumes idle-low sck with data set before the first edge. */
`timescale 1ns/100ps
module smt_slave_model (
  // Bus
  input wire logic sck,
  input wire logic sdo,
  input wire logic sel_act,
  output logic sdi,
  // Reply and capture
  input wire logic [7:0] reply,
  output logic [7:0] seen
);
  logic [7:0] in_r, out_r;
  int nin, nout;
  initial begin
    sdi = 1'b0;
    seen = 8'h00;
    nin = 0;
  end
  // Released line shows the inverse level, never a stale bit
  always @(negedge sel_act) sdi = ~sdi;
  always @(posedge sel_act) begin
    out_r = reply;
    sdi = reply[7];
    nout = 0;
    nin = 0;
  end
  always @(posedge sck) if (sel_act) begin
    in_r = {in_r[6:0], sdo};
    nin++;
    if (nin == 8) begin
      seen = in_r;
      nin = 0;
    end
  end
  always @(negedge sck) if (sel_act) begin
    nout++;
    out_r = (nout == 8) ? reply : out_r << 1;
    if (nout == 8) nout = 0;
    sdi = out_r[7];
  end
endmodule

// file: sim/testbench.sv
/* Self-checking bench for smt_master with a slave model.
   Assumes source clock bit 1 and baud 1: eight mclk per sck half. */
`timescale 1ns/100ps
module testbench;
  import smt_pkg::*;
  logic mclk, reset_n, cnt_wr, tx_valid, tx_ready, rx_valid, rx_ready;
  logic shift_empty_flag, count_zero_flag, czf_clr, sck_out, sdo_out;
  logic sdi_in, sel_out, sel_oe, sel_act;
  smt_ctl_s ctl;
  logic [7:0] srcs, tx_d, rx_d, seen;
  logic [CNT_W-1:0] cnt_wd, xfer_count;
  int num_errors, num_checks, edges;
  int cyc, last_cyc, half_cyc;
  // Slow enough for the three-flop input path to settle within a half
  localparam logic [BAUD_W-1:0] BAUD = 8'h01;
  smt_master u_smt_master (.mclk, .reset_n, .ctl, .clk_source_sel(SRC_HF_OSC),
    .baud_divisor(BAUD), .clk_sources(srcs), .xfer_count_wdata(cnt_wd),
    .xfer_count_low_wr(cnt_wr), .xfer_count, .tx_buffer_port(tx_d),
    .tx_valid, .tx_ready, .rx_buffer_port(rx_d), .rx_valid, .rx_ready,
    .shift_empty_flag, .count_zero_flag, .count_zero_clr(czf_clr),
    .sck_out, .sdo_out, .sdi_in, .sel_out, .sel_oe);
  assign sel_act = sel_oe && (sel_out != ctl.sel_polarity_ctl);
  smt_slave_model u_smt_slave_model (.sck(sck_out), .sdo(sdo_out),
    .sel_act, .sdi(sdi_in), .reply(8'hc3), .seen);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(negedge mclk) srcs <= srcs + 8'h01;
  always @(posedge mclk) cyc++;
  always @(sck_out) if (reset_n === 1'b1) begin
    edges++;
    half_cyc = cyc - last_cyc;
    last_cyc = cyc;
  end
  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic push(logic [7:0] b);
    @(negedge mclk);
    tx_d = b;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    tx_valid = 1'b0;
  endtask
  task automatic set_count(logic [CNT_W-1:0] v);
    @(negedge mclk);
    cnt_wd = v;
    cnt_wr = 1'b1;
    @(negedge mclk);
    cnt_wr = 1'b0;
  endtask
  task automatic pop();
    @(negedge mclk);
    while (rx_valid !== 1'b1) @(negedge mclk);
    chk("rx word", 16'hc3, 16'(rx_d));
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
  endtask
  // Long idle run means the engine has truly stopped or paused
  task automatic settle();
    int k;
    k = 0;
    while (k < 24) begin
      @(negedge mclk);
      k = (shift_empty_flag === 1'b1) ? k + 1 : 0;
    end
  endtask
  task automatic set_mode(logic tx, logic rx, logic cm);
    settle();
    ctl.tx_enable_ctl = tx;
    ctl.rx_enable_ctl = rx;
    ctl.counter_mode_ctl = cm;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    tally_and_finish();
  end
  // -------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------
  initial begin
    ctl = '0;
    ctl.master_en = 1'b1;
    ctl.sel_hw_ctl = 1'b1;
    ctl.sel_polarity_ctl = 1'b1;
    ctl.clk_phase_ctl = 1'b1;
    {srcs, tx_d, cnt_wd, cnt_wr, tx_valid, rx_ready, czf_clr} = '0;
    {num_errors, num_checks, edges} = '0;
    reset_n = 1'b0;
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    chk("idle", 16'h1, 16'(shift_empty_flag));
    chk("sel", 16'h1, 16'(sel_out));
    chk("sck", 16'h0, 16'(sck_out));
    ctl.sel_force_ctl = 1'b1;
    @(negedge mclk);
    chk("forced sel", 16'h0, 16'(sel_out));
    ctl.sel_hw_ctl = 1'b0;
    @(negedge mclk);
    chk("sw sel oe", 16'h0, 16'(sel_oe));
    chk("sw sel", 16'h1, 16'(sel_out));
    ctl.sel_hw_ctl = 1'b1;
    ctl.sel_force_ctl = 1'b0;
    $display("test reset done");
    push(8'ha1);
    push(8'hb2);
    repeat (40) @(negedge mclk);
    chk("queued", 16'h0, 16'(tx_ready));
    chk("off edges", 16'h0, 16'(edges));
    set_mode(1'b1, 1'b0, 1'b0);
    repeat (40) @(negedge mclk);
    chk("no count edges", 16'h0, 16'(edges));
    set_count(16'h0003);
    settle();
    chk("paused count", 16'h1, xfer_count);
    chk("sent", 16'hb2, 16'(seen));
    chk("sel held", 16'h0, 16'(sel_out));
    push(8'h5e);
    settle();
    chk("count", 16'h0, xfer_count);
    chk("zero flag", 16'h1, 16'(count_zero_flag));
    chk("sel drop", 16'h1, 16'(sel_out));
    chk("edges", 16'd48, 16'(edges));
    @(negedge mclk);
    czf_clr = 1'b1;
    @(negedge mclk);
    czf_clr = 1'b0;
    chk("flag clr", 16'h0, 16'(count_zero_flag));
    $display("test tx count mode done");
    set_mode(1'b0, 1'b0, 1'b0);
    push(8'h3c);
    set_mode(1'b0, 1'b1, 1'b0);
    repeat (40) @(negedge mclk);
    chk("rx no start", 16'd48, 16'(edges));
    set_count(16'h0003);
    settle();
    chk("rx full pause", 16'h1, xfer_count);
    pop();
    pop();
    pop();
    settle();
    chk("rx count", 16'h0, xfer_count);
    chk("rx sent", 16'h3c, 16'(seen));
    $display("test rx only done");
    set_mode(1'b1, 1'b0, 1'b1);
    // No count load in this mode, so the slave is selected by force
    ctl.sel_force_ctl = 1'b1;
    push(8'h77);
    settle();
    chk("wrap", 16'hfffe, xfer_count);
    chk("sent", 16'h77, 16'(seen));
    chk("no store", 16'h0, 16'(rx_valid));
    chk("edges", 16'd128, 16'(edges));
    // Source bit 1 of the counter has a four-cycle period
    chk("sck half", 16'(4 * (BAUD + 1)), 16'(half_cyc));
    $display("test tx free mode done");
    tally_and_finish();
  end
endmodule
